/* hdl/fmsp_uart.sv */
// Four-mode serial port with an AXI4-Lite register slave.
// Overview of operation
// - Receive register double-buffered; overrun loses one character.
// - Buffer write loads transmit, read returns receive.
// - Mode 0: eight bits, LSB first, clock on txd.
// - Mode 0 transmit: eight rising edges, then done flag.
// - Mode 0 receive: enable, flag clear, preset, activate.
// - Mode 0 receive samples falling edges, eight bits.
// - Mode 1 frame: start, eight data, stop.
// - Modes 1/3 rate from timer overflow, separate directions.
// - Mode 1 starts on bit clock; flag after bit 8.
// - Start on falling edge; mode 1 stores stop.
// - Modes 2/3: eleven bits, ninth bit taken from tb8 at start bit.
// - Mode 2 rate is clock/32 or clock/64.
// - Modes 2/3: start on bit clock; flag after ninth.
// - Modes 2/3: ninth bit stored in the same cycle as the done flag, at the stop bit.
// - Missing stop bit sets framing error flag.
// - Control bit 7 is framing error or mode bit.
// - Framing error flag cleared only by software.
// - Multiprocessor mode accepts only ninth-bit-one frames.
// - Multiprocessor bit ignored in mode 0; mode 1 checks stop.
// - Mode 0 divisor twelve, or two when fast.
`timescale 1ns/1ps
`default_nettype none
module fmsp_uart #(
   parameter int ADDR_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_timer_tick,
   input wire logic rx_timer_tick,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd_out
);
   typedef struct packed {
      fmsp_pkg::fmsp_ctl_t ctl;
      fmsp_pkg::fmsp_axi_t axi;
      fmsp_pkg::fmsp_tx_st_t tx_st;
      fmsp_pkg::fmsp_rx_st_t rx_st;
      logic [7:0] tx_hold;
      logic [7:0] rx_buf;
      logic [10:0] tx_shift;
      logic [8:0] rx_shift;
      logic [3:0] tx_cnt;
      logic [3:0] tx_os;
      logic [3:0] rx_cnt;
      logic [3:0] rx_os;
      logic tx_half;
      logic rx_half;
      logic rx_prev;
      logic txd;
      logic dout;
      logic doe;
   } fmsp_state_t;

   fmsp_state_t s_reg;
   fmsp_state_t s_next;
   logic rxd;
   logic m0_half;
   logic m2_tick;
   logic m0_run;
   logic [3:0] m0_period;
   logic [3:0] m2_period;
   logic async_mode;
   logic nine_bit;
   logic tx_os_tick;
   logic rx_os_tick;
   logic [7:0] ctl_byte;
   logic [7:0] rd_byte;
   logic rd_ok;
   logic [3:0] frame_len;
   logic [3:0] rx_data_len;
   logic [7:0] rx_data;
   logic rx_ninth;
   logic rx_accept;

   fmsp_sync3 u_rxd_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(rxd_in),
      .level(rxd)
   );

   assign m0_run = (s_reg.tx_st == fmsp_pkg::T_M0) || (s_reg.rx_st == fmsp_pkg::R_M0);
   assign m0_period = s_reg.ctl.m0_fast ? fmsp_pkg::M0_HALF_FAST : fmsp_pkg::M0_HALF_SLOW;
   assign m2_period = s_reg.ctl.doubler ? fmsp_pkg::M2_TICK_FAST : fmsp_pkg::M2_TICK_SLOW;

   // Half-period enable of the mode 0 shift clock.
   fmsp_tick_div u_m0_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .en(m0_run),
      .period(m0_period),
      .tick(m0_half)
   );

   // Oversampling enable for mode 2, sixteen per bit.
   fmsp_tick_div u_m2_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .en(s_reg.ctl.mode == fmsp_pkg::MODE2),
      .period(m2_period),
      .tick(m2_tick)
   );

   assign async_mode = s_reg.ctl.mode != fmsp_pkg::MODE0;
   assign nine_bit = s_reg.ctl.mode[1];
   assign frame_len = nine_bit ? fmsp_pkg::FRAME_9BIT : fmsp_pkg::FRAME_8BIT;
   assign rx_data_len = nine_bit ? fmsp_pkg::DATA_BITS + 4'h1 : fmsp_pkg::DATA_BITS;

   // Timer overflows are halved unless the doubler is set, so each direction gets its own rate.
   always_comb begin
      if (s_reg.ctl.mode == fmsp_pkg::MODE2) begin
         tx_os_tick = m2_tick;
         rx_os_tick = m2_tick;
      end else begin
         tx_os_tick = tx_timer_tick && (s_reg.ctl.doubler || s_reg.tx_half);
         rx_os_tick = rx_timer_tick && (s_reg.ctl.doubler || s_reg.rx_half);
      end
   end

   always_comb begin
      ctl_byte = {s_reg.ctl.fe_sel ? s_reg.ctl.fe : s_reg.ctl.mode[1], s_reg.ctl.mode[0],
                  s_reg.ctl.mpe, s_reg.ctl.ren, s_reg.ctl.tb8, s_reg.ctl.rb8, s_reg.ctl.ti, s_reg.ctl.ri};
      rd_ok = 1'b1;
      case (s_axi_araddr[3:0])
         fmsp_pkg::ADDR_BUFFER: rd_byte = s_reg.rx_buf;
         fmsp_pkg::ADDR_CONTROL: rd_byte = ctl_byte;
         fmsp_pkg::ADDR_POWER: rd_byte = {s_reg.ctl.doubler, s_reg.ctl.fe_sel, 6'h00};
         fmsp_pkg::ADDR_AUX: rd_byte = {2'h0, s_reg.ctl.m0_fast, 5'h00};
         default: begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end

   assign rx_data = nine_bit ? s_reg.rx_shift[7:0] : s_reg.rx_shift[8:1];
   assign rx_ninth = nine_bit ? s_reg.rx_shift[8] : rxd;
   // An unread character blocks the new one, which is the one that is lost.
   assign rx_accept = !s_reg.ctl.ri && (!s_reg.ctl.mpe || rx_ninth);

   always_comb begin
      s_next = s_reg;
      // Register slave: address and data are taken in either order, the write acts once both are held.
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.axi.aw_got = 1'b1;
         s_next.axi.waddr = s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.axi.w_got = 1'b1;
         s_next.axi.wbyte = s_axi_wdata[7:0];
         s_next.axi.wen = s_axi_wstrb[0];
      end
      if (s_reg.axi.bvalid && s_axi_bready) begin
         s_next.axi.bvalid = 1'b0;
      end
      if (s_reg.axi.rvalid && s_axi_rready) begin
         s_next.axi.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.axi.rvalid = 1'b1;
         s_next.axi.rdata = {24'h000000, rd_byte};
         s_next.axi.rresp = rd_ok ? fmsp_pkg::RESP_OKAY : fmsp_pkg::RESP_SLVERR;
      end
      if (s_reg.axi.aw_got && s_reg.axi.w_got && !s_reg.axi.bvalid) begin
         s_next.axi.aw_got = 1'b0;
         s_next.axi.w_got = 1'b0;
         s_next.axi.bvalid = 1'b1;
         s_next.axi.bresp = fmsp_pkg::RESP_OKAY;
         case (s_reg.axi.waddr)
            fmsp_pkg::ADDR_BUFFER: begin
               if (s_reg.axi.wen) begin
                  s_next.tx_hold = s_reg.axi.wbyte;
                  s_next.tx_cnt = 4'h0;
                  if (async_mode) begin
                     s_next.tx_st = fmsp_pkg::T_WAIT;
                  end else begin
                     s_next.tx_st = fmsp_pkg::T_M0;
                     s_next.tx_shift = {3'h7, s_reg.axi.wbyte};
                     s_next.txd = 1'b1;
                     s_next.dout = s_reg.axi.wbyte[0];
                     s_next.doe = 1'b1;
                  end
               end
            end
            fmsp_pkg::ADDR_CONTROL: begin
               if (s_reg.axi.wen) begin
                  if (s_reg.ctl.fe_sel) begin
                     s_next.ctl.fe = s_reg.axi.wbyte[fmsp_pkg::CTL_MODE_HI];
                  end else begin
                     s_next.ctl.mode[1] = s_reg.axi.wbyte[fmsp_pkg::CTL_MODE_HI];
                  end
                  s_next.ctl.mode[0] = s_reg.axi.wbyte[fmsp_pkg::CTL_MODE_LO];
                  s_next.ctl.mpe = s_reg.axi.wbyte[fmsp_pkg::CTL_MPE];
                  s_next.ctl.ren = s_reg.axi.wbyte[fmsp_pkg::CTL_REN];
                  s_next.ctl.tb8 = s_reg.axi.wbyte[fmsp_pkg::CTL_TB8];
                  s_next.ctl.rb8 = s_reg.axi.wbyte[fmsp_pkg::CTL_RB8];
                  s_next.ctl.ti = s_reg.axi.wbyte[fmsp_pkg::CTL_TI];
                  s_next.ctl.ri = s_reg.axi.wbyte[fmsp_pkg::CTL_RI];
               end
            end
            fmsp_pkg::ADDR_POWER: begin
               if (s_reg.axi.wen) begin
                  s_next.ctl.doubler = s_reg.axi.wbyte[fmsp_pkg::PWR_DOUBLER];
                  s_next.ctl.fe_sel = s_reg.axi.wbyte[fmsp_pkg::PWR_FE_SEL];
               end
            end
            fmsp_pkg::ADDR_AUX: begin
               if (s_reg.axi.wen) begin
                  s_next.ctl.m0_fast = s_reg.axi.wbyte[fmsp_pkg::AUX_M0_FAST];
               end
            end
            default: begin
               s_next.axi.bresp = fmsp_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Hardware flag sets come after the software write so that a set in the same cycle wins.
      if (tx_timer_tick) begin
         s_next.tx_half = !s_reg.tx_half;
      end
      if (rx_timer_tick) begin
         s_next.rx_half = !s_reg.rx_half;
      end
      if (tx_os_tick) begin
         s_next.tx_os = s_reg.tx_os + 4'h1;
      end
      if (rx_os_tick) begin
         s_next.rx_prev = rxd;
      end

      case (s_reg.tx_st)
         fmsp_pkg::T_IDLE: begin
         end
         fmsp_pkg::T_WAIT: begin
            if (tx_os_tick && s_reg.tx_os == fmsp_pkg::OS_LAST) begin
               s_next.tx_st = fmsp_pkg::T_ASYNC;
               s_next.tx_shift = {1'b1, nine_bit ? s_reg.ctl.tb8 : 1'b1, s_reg.tx_hold, 1'b0};
               s_next.txd = 1'b0;
            end
         end
         fmsp_pkg::T_ASYNC: begin
            if (tx_os_tick && s_reg.tx_os == fmsp_pkg::OS_LAST) begin
               s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
               s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
               s_next.txd = s_reg.tx_shift[1];
               if (s_reg.tx_cnt + 4'h1 == frame_len - 4'h1) begin
                  s_next.ctl.ti = 1'b1;
               end
               if (s_reg.tx_cnt + 4'h1 == frame_len) begin
                  s_next.tx_st = fmsp_pkg::T_IDLE;
                  s_next.txd = 1'b1;
               end
            end
         end
         fmsp_pkg::T_M0: begin
            if (m0_half) begin
               s_next.txd = !s_reg.txd;
               if (!s_reg.txd) begin
                  s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                  s_next.dout = s_reg.tx_shift[1];
                  s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                  if (s_reg.tx_cnt + 4'h1 == fmsp_pkg::DATA_BITS) begin
                     s_next.ctl.ti = 1'b1;
                     s_next.tx_st = fmsp_pkg::T_IDLE;
                     s_next.doe = 1'b0;
                  end
               end
            end
         end
         default: s_next.tx_st = fmsp_pkg::T_IDLE;
      endcase

      case (s_reg.rx_st)
         fmsp_pkg::R_IDLE: begin
            if (!async_mode && s_reg.ctl.ren && !s_reg.ctl.ri && s_reg.tx_st == fmsp_pkg::T_IDLE) begin
               s_next.rx_st = fmsp_pkg::R_PRE;
            end else if (async_mode && s_reg.ctl.ren && rx_os_tick && s_reg.rx_prev && !rxd) begin
               s_next.rx_st = fmsp_pkg::R_START;
               s_next.rx_os = 4'h0;
            end
         end
         fmsp_pkg::R_PRE: begin
            s_next.rx_shift = {1'b1, fmsp_pkg::M0_RX_PRESET};
            s_next.rx_cnt = 4'h0;
            s_next.txd = 1'b1;
            s_next.rx_st = fmsp_pkg::R_M0;
         end
         fmsp_pkg::R_M0: begin
            if (m0_half) begin
               s_next.txd = !s_reg.txd;
               if (s_reg.txd) begin
                  s_next.rx_shift = {1'b1, rxd, s_reg.rx_shift[7:1]};
                  s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
               end else if (s_reg.rx_cnt == fmsp_pkg::DATA_BITS) begin
                  s_next.rx_buf = s_reg.rx_shift[7:0];
                  s_next.ctl.ri = 1'b1;
                  s_next.rx_st = fmsp_pkg::R_IDLE;
               end
            end
         end
         fmsp_pkg::R_START: begin
            if (rx_os_tick) begin
               s_next.rx_os = s_reg.rx_os + 4'h1;
               if (s_reg.rx_os == fmsp_pkg::OS_MID) begin
                  s_next.rx_os = 4'h0;
                  s_next.rx_cnt = 4'h0;
                  // A glitch shorter than half a bit must not start a character.
                  s_next.rx_st = rxd ? fmsp_pkg::R_IDLE : fmsp_pkg::R_BITS;
               end
            end
         end
         fmsp_pkg::R_BITS: begin
            if (rx_os_tick) begin
               s_next.rx_os = s_reg.rx_os + 4'h1;
               if (s_reg.rx_os == fmsp_pkg::OS_LAST) begin
                  s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                  if (s_reg.rx_cnt != rx_data_len) begin
                     s_next.rx_shift = {rxd, s_reg.rx_shift[8:1]};
                  end else begin
                     s_next.rx_st = fmsp_pkg::R_IDLE;
                     if (!rxd) begin
                        s_next.ctl.fe = 1'b1;
                     end
                     if (rx_accept) begin
                        s_next.rx_buf = rx_data;
                        s_next.ctl.rb8 = rx_ninth;
                        s_next.ctl.ri = 1'b1;
                     end
                  end
               end
            end
         end
         default: s_next.rx_st = fmsp_pkg::R_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
         s_reg.ctl <= fmsp_pkg::fmsp_ctl_t'(12'h000);
         s_reg.tx_st <= fmsp_pkg::T_IDLE;
         s_reg.rx_st <= fmsp_pkg::R_IDLE;
         s_reg.tx_hold <= fmsp_pkg::BUFFER_RST;
         s_reg.rx_buf <= fmsp_pkg::BUFFER_RST;
         s_reg.txd <= 1'b1;
         s_reg.rx_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign s_axi_awready = !s_reg.axi.aw_got && !s_reg.axi.bvalid;
   assign s_axi_wready = !s_reg.axi.w_got && !s_reg.axi.bvalid;
   assign s_axi_bvalid = s_reg.axi.bvalid;
   assign s_axi_bresp = s_reg.axi.bresp;
   assign s_axi_arready = !s_reg.axi.rvalid;
   assign s_axi_rvalid = s_reg.axi.rvalid;
   assign s_axi_rdata = s_reg.axi.rdata;
   assign s_axi_rresp = s_reg.axi.rresp;
   assign txd_out = s_reg.txd;
   assign rxd_out = s_reg.dout;
   assign rxd_oe = s_reg.doe;
endmodule
`default_nettype wire

/* hdl/fmsp_pkg.sv */
// Package with the serial port's register map, field layout, timing counts and state types.
package fmsp_pkg;
   localparam logic [3:0] ADDR_BUFFER = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_POWER = 4'h8;
   localparam logic [3:0] ADDR_AUX = 4'hC;
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_MPE = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_TB8 = 3;
   localparam int CTL_RB8 = 2;
   localparam int CTL_TI = 1;
   localparam int CTL_RI = 0;
   localparam int PWR_DOUBLER = 7;
   localparam int PWR_FE_SEL = 6;
   localparam int AUX_M0_FAST = 5;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] BUFFER_RST = 8'h00;
   localparam logic [1:0] MODE0 = 2'h0;
   localparam logic [1:0] MODE1 = 2'h1;
   localparam logic [1:0] MODE2 = 2'h2;
   localparam logic [1:0] MODE3 = 2'h3;
   localparam int M0_DIV_SLOW = 12;
   localparam int M0_DIV_FAST = 2;
   localparam int M2_DIV_SLOW = 64;
   localparam int M2_DIV_FAST = 32;
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] M0_HALF_SLOW = 4'(M0_DIV_SLOW / 2);
   localparam logic [3:0] M0_HALF_FAST = 4'(M0_DIV_FAST / 2);
   localparam logic [3:0] M2_TICK_SLOW = 4'(M2_DIV_SLOW / OVERSAMPLE);
   localparam logic [3:0] M2_TICK_FAST = 4'(M2_DIV_FAST / OVERSAMPLE);
   localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] OS_MID = 4'(OVERSAMPLE / 2 - 1);
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] FRAME_8BIT = 4'hA;
   localparam logic [3:0] FRAME_9BIT = 4'hB;
   localparam logic [7:0] M0_RX_PRESET = 8'hFE;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      T_IDLE = 4'b0001,
      T_WAIT = 4'b0010,
      T_ASYNC = 4'b0100,
      T_M0 = 4'b1000
   } fmsp_tx_st_t;

   typedef enum logic [4:0] {
      R_IDLE = 5'b00001,
      R_PRE = 5'b00010,
      R_M0 = 5'b00100,
      R_START = 5'b01000,
      R_BITS = 5'b10000
   } fmsp_rx_st_t;

   typedef struct packed {
      logic [1:0] mode;
      logic mpe;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
      logic fe;
      logic doubler;
      logic fe_sel;
      logic m0_fast;
   } fmsp_ctl_t;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [3:0] waddr;
      logic [7:0] wbyte;
      logic wen;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } fmsp_axi_t;

   typedef struct packed {
      logic [2:0] sync;
      logic level;
   } fmsp_sync_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic pulse;
   } fmsp_div_t;
endpackage

/* hdl/fmsp_sync3.sv */
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
`default_nettype none
module fmsp_sync3 (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic level
);
   fmsp_pkg::fmsp_sync_t s_reg;
   fmsp_pkg::fmsp_sync_t s_next;
   always_comb begin
      s_next = s_reg;
      s_next.sync = {s_reg.sync[1:0], pin};
      // The first stage feeds only the second, so no logic sees a metastable value.
      if (s_reg.sync[1] == s_reg.sync[2]) begin
         s_next.level = s_reg.sync[2];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '{sync: 3'h7, level: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

   assign level = s_reg.level;
endmodule
`default_nettype wire

/* hdl/fmsp_tick_div.sv */
// Clock-enable divider that pulses once every period cycles while enabled.
`timescale 1ns/1ps
`default_nettype none
module fmsp_tick_div (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic en,
   input wire logic [3:0] period,
   output logic tick
);
   fmsp_pkg::fmsp_div_t s_reg;
   fmsp_pkg::fmsp_div_t s_next;
   always_comb begin
      s_next = s_reg;
      s_next.pulse = 1'b0;
      if (!en) begin
         s_next.cnt = 4'h0;
      end else if (s_reg.cnt >= period - 4'h1) begin
         s_next.cnt = 4'h0;
         s_next.pulse = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 4'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '{cnt: 4'h0, pulse: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.pulse;
endmodule
`default_nettype wire

/* verif/fmsp_checker.sv */
// Assertions on the serial port's bus handshakes and mode 0 shift clock.
`timescale 1ns/1ps
`default_nettype none
module fmsp_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rxd_oe,
   input wire logic txd_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] rise_cnt;
   // Counting starts when the pin is taken, so receive clocking never pollutes it.
   always_ff @(posedge aclk) begin
      if (!aresetn || $rose(rxd_oe)) begin
         rise_cnt <= 4'h0;
      end else if ($rose(txd_out)) begin
         rise_cnt <= rise_cnt + 4'h1;
      end
   end
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early.");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response dropped early.");
   r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set.");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late.");
   w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late.");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending.");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending.");
   m0_edges_a: assert property ($fell(rxd_oe) |-> rise_cnt + {3'h0, $rose(txd_out)} == 4'h8)
      else $error("shift clock edge count wrong.");
   m0_idle_a: assert property ($fell(rxd_oe) |-> txd_out)
      else $error("shift clock not idle high.");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($fell(rxd_oe));
endmodule
bind fmsp_uart fmsp_checker i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rxd_oe(rxd_oe), .txd_out(txd_out));
`default_nettype wire

/* verif/fmsp_partner.sv */
// Remote serial node: frame sender, frame receiver and mode 0 shift capture.
`timescale 1ns/1ps
`default_nettype none
module fmsp_partner (
   input wire logic aclk,
   input wire logic txd_out,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   output logic rxd_in
);
   int bit_clks = 16;
   logic [7:0] m0_byte = 8'h00;
   logic m0_hold = 1'b0;
   logic prev_clk = 1'b1;
   logic prev_oe = 1'b0;
   initial rxd_in = 1'b1;
   // The bit is taken from the low phase, since the port moves on at the rising edge.
   always @(posedge aclk) begin
      prev_clk <= txd_out;
      prev_oe <= rxd_oe;
      if (!txd_out) m0_hold <= rxd_out;
      if ((rxd_oe || prev_oe) && txd_out && !prev_clk) m0_byte <= {m0_hold, m0_byte[7:1]};
   end
   task automatic send(input logic [8:0] d, input int nb, input logic stop);
      logic [10:0] f;
      f = 11'h7FF;
      f[0] = 1'b0;
      for (int i = 0; i < nb; i++) f[i + 1] = d[i];
      f[nb + 1] = stop;
      for (int i = 0; i < nb + 2; i++) begin
         rxd_in <= f[i];
         repeat (bit_clks) @(posedge aclk);
      end
      rxd_in <= 1'b1;
   endtask
   task automatic recv(output logic [9:0] d, input int nb);
      d = 10'h000;
      do @(posedge aclk); while (txd_out !== 1'b0);
      repeat (bit_clks / 2) @(posedge aclk);
      for (int i = 0; i <= nb; i++) begin
         repeat (bit_clks) @(posedge aclk);
         d[i] = txd_out;
      end
   endtask
endmodule
`default_nettype wire

/* verif/four_mode_serial_port_tb.sv */
// Self-checking bench for the four-mode serial port.
`timescale 1ns/1ps
`default_nettype none
module four_mode_serial_port_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awready, wready, bvalid, arready, rvalid, rxd_in, rxd_out, rxd_oe, txd_out;
   logic [1:0] bresp, rresp, r;
   logic [9:0] f;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   always #2 aclk = ~aclk;
   fmsp_uart i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_timer_tick(1'b1),
      .rx_timer_tick(1'b1), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
   fmsp_partner i_partner (.aclk(aclk), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Each access waits an edge first, so a strobe is never driven twice in one step.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] s);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      s = rresp;
      rready <= 1'b0;
   endtask
   task automatic poll(input int b);
      for (int i = 0; i < 300; i++) begin
         rd(fmsp_pkg::ADDR_CONTROL, v, r);
         if (v[b] === 1'b1) break;
      end
   endtask
   task automatic t_regs;
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, fmsp_pkg::CONTROL_RST);
      rd(4'h2, v, r);
      chk(r, fmsp_pkg::RESP_SLVERR);
      chk(v, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_m0_tx;
      wr(fmsp_pkg::ADDR_AUX, 8'h20);
      wr(fmsp_pkg::ADDR_CONTROL, 8'h00);
      wr(fmsp_pkg::ADDR_BUFFER, 8'hC3);
      poll(fmsp_pkg::CTL_TI);
      chk(v[fmsp_pkg::CTL_TI], 1'b1);
      chk(i_partner.m0_byte, 8'hC3);
      wr(fmsp_pkg::ADDR_CONTROL, 8'h10);
      poll(fmsp_pkg::CTL_RI);
      rd(fmsp_pkg::ADDR_BUFFER, v, r);
      chk(v, 32'h0000_00FF);
      $display("test m0_tx done");
   endtask
   task automatic t_m1_tx;
      wr(fmsp_pkg::ADDR_CONTROL, 8'h50);
      fork
         i_partner.recv(f, 8);
         wr(fmsp_pkg::ADDR_BUFFER, 8'hA5);
      join
      chk(f, 10'h1A5);
      poll(fmsp_pkg::CTL_TI);
      chk(v[fmsp_pkg::CTL_TI], 1'b1);
      $display("test m1_tx done");
   endtask
   task automatic t_m1_rx;
      wr(fmsp_pkg::ADDR_CONTROL, 8'h50);
      i_partner.send(9'h03C, 8, 1'b1);
      i_partner.send(9'h081, 8, 1'b1);
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, 8'h55);
      rd(fmsp_pkg::ADDR_BUFFER, v, r);
      chk(v, 8'h3C);
      $display("test m1_rx done");
   endtask
   task automatic t_fe;
      wr(fmsp_pkg::ADDR_POWER, 8'hC0);
      wr(fmsp_pkg::ADDR_CONTROL, 8'h70);
      i_partner.send(9'h011, 8, 1'b0);
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, 8'hF0);
      i_partner.send(9'h022, 8, 1'b1);
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, 8'hF5);
      wr(fmsp_pkg::ADDR_CONTROL, 8'h50);
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, 8'h50);
      wr(fmsp_pkg::ADDR_POWER, 8'h80);
      $display("test fe done");
   endtask
   task automatic t_m3;
      wr(fmsp_pkg::ADDR_CONTROL, 8'hF0);
      i_partner.send(9'h033, 9, 1'b1);
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, 8'hF0);
      i_partner.send(9'h144, 9, 1'b1);
      rd(fmsp_pkg::ADDR_CONTROL, v, r);
      chk(v, 8'hF5);
      rd(fmsp_pkg::ADDR_BUFFER, v, r);
      chk(v, 8'h44);
      $display("test m3 done");
   endtask
   task automatic t_m2_tx;
      wr(fmsp_pkg::ADDR_CONTROL, 8'h98);
      i_partner.bit_clks = 32;
      fork
         i_partner.recv(f, 9);
         wr(fmsp_pkg::ADDR_BUFFER, 8'h5A);
      join
      chk(f, 10'h35A);
      poll(fmsp_pkg::CTL_TI);
      chk(v[fmsp_pkg::CTL_TI], 1'b1);
      i_partner.bit_clks = 16;
      $display("test m2_tx done");
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      wr(fmsp_pkg::ADDR_POWER, 8'h80);
      t_m0_tx();
      t_m1_tx();
      t_m1_rx();
      t_fe();
      t_m3();
      t_m2_tx();
      tally_and_finish();
   end
endmodule
`default_nettype wire
